/* ibfsm_framer.sv */
// Mapping end: places bearer, access signalling and fast signalling bits on the pairs.
`timescale 1ns/1ps
`include "ibfsm_cfg.svh"

module ibfsm_framer
	import ibfsm_pkg::*;
#(
	parameter int SB_PER_FRAME = `IBFSM_SB_PER_FRAME
) (
	input  wire logic         clock_in,
	input  wire logic         sys_rst_in,
	input  wire logic [2:0]   acc_count_in,
	input  wire logic         four_wire_in,
	input  wire logic         fs_enable_in,
	input  wire logic         tick_in,
	input  wire ibfsm_bdata_t b_data_in,
	input  wire ibfsm_ddata_t d_data_in,
	input  wire logic         fs_bit_in,
	output logic              sb_take_out,
	output logic              fs_active_out,
	output logic [2:0]        acc_count_out,
	ibfsm_link_if.tx          link
);

	// Sub-block counter width; one bit is enough for a frame of two sub-blocks.
	localparam int SB_W = (SB_PER_FRAME > 1) ? $clog2(SB_PER_FRAME) : 1;
	localparam logic [SB_W-1:0] SB_LAST = SB_W'(SB_PER_FRAME - 1);

	// Number of bits one pair carries in one sub-block.
	// Two-wire above three accesses moves four signalling pairs into octet slot one.
	function automatic logic [6:0] sb_len(input logic [2:0] c, input logic fw);
		logic [7:0] k;
		k = {5'h00, c};
		if (fw) return 7'(8'h01 + k + (k << 3));
		if (k < 8'h04) return 7'(8'h01 + (k << 1) + (k << 4));
		return 7'(8'h01 + ((k - 8'h04) << 1) + (((k << 1) + 8'h01) << 3));
	endfunction : sb_len

	// Registered state of the mapping end.
	ibfsm_state_e     state_q;
	logic [2:0]       cnt_q;
	logic             four_q;
	logic             fs_on_q;
	logic [6:0]       pos_q;
	logic [6:0]       last_q;
	logic [SB_W-1:0]  sb_q;
	ibfsm_bdata_t     b_cur_q;
	ibfsm_ddata_t     d_cur_q;
	ibfsm_ddata_t     d_hold_q;
	logic             fs_cur_q;
	logic [1:0]       pair_bit_q;
	logic             bit_valid_q;
	logic             sb_start_q;
	logic             fr_start_q;
	logic             take_q;

	// Decode of the current bit position on each pair.
	logic             sb_end;
	logic             load;
	logic             cfg_load;
	logic [2:0]       cnt_d;
	ibfsm_kind_e      kind0;
	ibfsm_kind_e      kind1;
	logic [2:0]       acc0;
	logic [2:0]       acc1;
	logic [3:0]       idx0;
	logic [3:0]       idx1;
	logic [1:0]       sel;

	// A sub-block ends on the tick that sends its last bit.
	assign sb_end = (state_q == ST_RUN) && tick_in && (pos_q == last_q);
	assign load = (state_q == ST_WAIT) || sb_end;
	assign cfg_load = (state_q == ST_WAIT) || (sb_end && sb_q == SB_LAST);
	assign cnt_d = ibfsm_clamp_count(acc_count_in); // [RULE3]

	// One decoder per pair; pair two stays idle in two-wire operation.
	ibfsm_slot_map u_map0 (
		.pos_in       (pos_q),
		.pair_in      (1'b0),
		.cnt_in       (cnt_q),
		.four_wire_in (four_q),
		.kind_out     (kind0),
		.acc_out      (acc0),
		.idx_out      (idx0)
	);

	ibfsm_slot_map u_map1 (
		.pos_in       (pos_q),
		.pair_in      (1'b1),
		.cnt_in       (cnt_q),
		.four_wire_in (four_q),
		.kind_out     (kind1),
		.acc_out      (acc1),
		.idx_out      (idx1)
	);

	// Picks the line bit for one decoded slot.
	function automatic logic pick(
		input ibfsm_kind_e  kd,
		input logic [2:0]   a,
		input logic [3:0]   i,
		input ibfsm_bdata_t b,
		input ibfsm_ddata_t d,
		input logic         fs,
		input logic         fs_on
	);
		case (kd)
			KIND_FS: return fs_on ? fs : `IBFSM_IDLE_BIT;
			KIND_B:  return b[a][4'hF - i];
			KIND_D:  return d[a][i[0]];
			default: return `IBFSM_IDLE_BIT;
		endcase
	endfunction : pick

	// Line bits for the next tick, one per pair.
	assign sel[0] = pick(kind0, acc0, idx0, b_cur_q, d_cur_q, fs_cur_q, fs_on_q);
	assign sel[1] = pick(kind1, acc1, idx1, b_cur_q, d_cur_q, fs_cur_q, fs_on_q);

	// Start-up: one cycle to take the configuration, then the line runs.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state_q <= ST_WAIT;
		end else begin
			case (state_q)
				ST_WAIT: state_q <= ST_RUN;
				ST_RUN:  state_q <= ST_RUN;
				default: state_q <= ST_WAIT;
			endcase
		end
	end

	// Configuration is only taken between frames.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cnt_q <= `IBFSM_MIN_ACC;
			four_q <= 1'b0;
			fs_on_q <= 1'b0;
			last_q <= 7'h00;
		end else if (cfg_load) begin
			cnt_q <= cnt_d; // [RULE20]
			four_q <= four_wire_in; // [RULE20] [RULE11]
			fs_on_q <= ibfsm_fs_active(fs_enable_in, cnt_d); // [RULE18] [RULE19]
			last_q <= sb_len(cnt_d, four_wire_in) - 7'h01;
		end
	end

	// Bit position within the sub-block and sub-block number within the frame.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || state_q == ST_WAIT) begin
			pos_q <= 7'h00;
			sb_q <= '0;
		end else if (sb_end) begin
			pos_q <= 7'h00;
			sb_q <= (sb_q == SB_LAST) ? '0 : sb_q + 1'b1;
		end else if (tick_in) begin
			pos_q <= pos_q + 7'h01;
		end
	end

	// User data for the next sub-block; D bits wait one sub-block behind their B bits.
	// Held D bits reset to ones, so the first sub-block sends idle signalling.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			b_cur_q <= '0;
			d_cur_q <= '1;
			d_hold_q <= '1;
			fs_cur_q <= `IBFSM_IDLE_BIT;
			take_q <= 1'b0;
		end else begin
			take_q <= load;
			if (load) begin
				b_cur_q <= b_data_in;
				d_cur_q <= d_hold_q; // [RULE4] [RULE5]
				d_hold_q <= d_data_in; // [RULE4] [RULE5]
				fs_cur_q <= fs_bit_in; // [RULE16] [RULE17]
			end
		end
	end

	// Line side registers.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			pair_bit_q <= 2'h3;
			bit_valid_q <= 1'b0;
			sb_start_q <= 1'b0;
			fr_start_q <= 1'b0;
		end else begin
			bit_valid_q <= (state_q == ST_RUN) && tick_in;
			if ((state_q == ST_RUN) && tick_in) begin
				pair_bit_q <= sel; // [RULE1] [RULE14]
				sb_start_q <= (pos_q == 7'h00);
				fr_start_q <= (pos_q == 7'h00) && (sb_q == '0);
			end else begin
				sb_start_q <= 1'b0;
				fr_start_q <= 1'b0;
			end
		end
	end

	// Every output comes straight from a register.
	assign link.pair_bit = pair_bit_q;
	assign link.bit_valid = bit_valid_q;
	assign link.sb_start = sb_start_q;
	assign link.fr_start = fr_start_q;
	assign sb_take_out = take_q;
	assign fs_active_out = fs_on_q;
	assign acc_count_out = cnt_q;

endmodule : ibfsm_framer

/* ibfsm_cfg.svh */
// Constants shared by both ends of the fast signalling payload mapper.
// What this block does
// RULE1 - Single-bit slots precede octet slots in sub-blocks.
// RULE2 - Fast signalling rides first single-bit slot always.
// RULE3 - Carry any access count from one to six.
// RULE4 - D bits sent one sub-block after B bits.
// RULE5 - Last sub-block D bits go into next frame.
// RULE6 - Two-wire, up to three: octets 2k-1,2k; bits 2k,2k+1.
// RULE7 - Third access: octets 5,6; single bits 6,7.
// RULE8 - Four accesses: octets 2k,2k+1; D in octet 1.
// RULE9 - Five accesses: first uses bits 2,3; rest octet 1.
// RULE10 - Six accesses: two use single bits; four octet 1.
// RULE11 - Four-wire, up to three: same as two-wire allocation.
// RULE12 - Four-wire, four to six: octets 2k-1,2k; bits 2k,2k+1.
// RULE13 - Four-wire: fast signalling first bit on both pairs.
// RULE14 - Four-wire: even single bits group with odd octets.
// RULE15 - That group travels on pair one, others pair two.
// RULE16 - Status messages ride operations channel or fast channel.
// RULE17 - Either line end may originate signalling messages.
// RULE18 - Fast channel mandatory above four accesses, else optional.
// RULE19 - Fast channel optional for latency or crowded channel.
// RULE20 - Configuration is static, applied only at frame boundary.
`ifndef IBFSM_CFG_SVH
`define IBFSM_CFG_SVH

`define IBFSM_MAX_ACC        3'h6
`define IBFSM_MIN_ACC        3'h1
`define IBFSM_FS_FORCE_ABOVE 3'h4
`define IBFSM_SB_PER_FRAME   12
`define IBFSM_IDLE_BIT       1'h1
`define IBFSM_OCTET_PAIR_W   16

`endif

/* ibfsm_pkg.sv */
// Types and shared helper functions of the fast signalling payload mapper.
`include "ibfsm_cfg.svh"

package ibfsm_pkg;

	typedef enum logic [1:0] {
		KIND_IDLE = 2'b00,
		KIND_FS   = 2'b01,
		KIND_B    = 2'b10,
		KIND_D    = 2'b11
	} ibfsm_kind_e;

	typedef enum logic {
		ST_WAIT = 1'b0,
		ST_RUN  = 1'b1
	} ibfsm_state_e;

	typedef logic [5:0][`IBFSM_OCTET_PAIR_W-1:0] ibfsm_bdata_t;
	typedef logic [5:0][1:0]                     ibfsm_ddata_t;

	// Forces the access count into the supported range.
	function automatic logic [2:0] ibfsm_clamp_count(input logic [2:0] c);
		if (c < `IBFSM_MIN_ACC) return `IBFSM_MIN_ACC;
		if (c > `IBFSM_MAX_ACC) return `IBFSM_MAX_ACC;
		return c;
	endfunction : ibfsm_clamp_count

	// The fast channel is in use when asked for or when the count demands it.
	function automatic logic ibfsm_fs_active(input logic en, input logic [2:0] c);
		return en || (c > `IBFSM_FS_FORCE_ABOVE);
	endfunction : ibfsm_fs_active

endpackage : ibfsm_pkg

/* ibfsm_link_if.sv */
// Payload sub-block link between the mapping end and the extracting end.
`timescale 1ns/1ps

interface ibfsm_link_if;
	logic [1:0] pair_bit;
	logic       bit_valid;
	logic       sb_start;
	logic       fr_start;

	modport tx (
		output pair_bit,
		output bit_valid,
		output sb_start,
		output fr_start
	);

	modport rx (
		input  pair_bit,
		input  bit_valid,
		input  sb_start,
		input  fr_start
	);
endinterface : ibfsm_link_if

/* ibfsm_slot_map.sv */
// Decodes a bit position of a pair into channel kind, access and bit index.
`timescale 1ns/1ps

module ibfsm_slot_map
	import ibfsm_pkg::*;
(
	input  wire logic [6:0]  pos_in,
	input  wire logic        pair_in,
	input  wire logic [2:0]  cnt_in,
	input  wire logic        four_wire_in,
	output ibfsm_kind_e      kind_out,
	output logic [2:0]       acc_out,
	output logic [3:0]       idx_out
);

	always_comb begin
		logic [7:0] p;
		logic [7:0] k;
		logic [7:0] zn;
		logic [7:0] zc;
		logic [7:0] z;
		logic [7:0] off;
		logic [7:0] ts;
		p = {1'h0, pos_in};
		k = {5'h00, cnt_in};
		zn = (four_wire_in || k < 8'h04) ? k : k - 8'h04;
		zc = 8'h01 + (zn << 1);
		z = 8'h00;
		off = 8'h00;
		ts = 8'h00;
		kind_out = KIND_IDLE;
		acc_out = 3'h0;
		idx_out = 4'h0;
		if (p == 8'h00) begin
			if (four_wire_in || !pair_in) kind_out = KIND_FS; // [RULE2] [RULE13]
		end else if (four_wire_in) begin
			if (p <= k) begin
				z = (p << 1) + {7'h00, pair_in}; // [RULE14] [RULE15]
			end else if (p < 8'h01 + k + (k << 3)) begin
				off = p - 8'h01 - k;
				ts = ((off >> 3) << 1) + 8'h01 + {7'h00, pair_in}; // [RULE14] [RULE15]
			end
		end else if (!pair_in) begin
			if (p < zc) begin
				z = p + 8'h01; // [RULE1]
			end else begin
				off = p - zc;
				ts = (off >> 3) + 8'h01; // [RULE1]
			end
		end
		if (z >= 8'h02) begin
			kind_out = KIND_D; // [RULE6] [RULE7] [RULE9] [RULE10] [RULE12]
			acc_out = 3'((z - 8'h02) >> 1);
			idx_out = {3'h0, z[0]};
		end else if (ts != 8'h00) begin
			if (four_wire_in || k < 8'h04) begin
				if (ts <= (k << 1)) begin
					kind_out = KIND_B; // [RULE6] [RULE7] [RULE11] [RULE12]
					acc_out = 3'((ts - 8'h01) >> 1);
					idx_out = {~ts[0], off[2:0]};
				end
			end else if (ts == 8'h01) begin
				kind_out = KIND_D; // [RULE8] [RULE9] [RULE10]
				acc_out = 3'(zn + {6'h00, off[2:1]});
				idx_out = {3'h0, off[0]};
			end else if (ts <= (k << 1) + 8'h01) begin
				kind_out = KIND_B; // [RULE8] [RULE9] [RULE10]
				acc_out = 3'((ts - 8'h02) >> 1);
				idx_out = {ts[0], off[2:0]};
			end
		end
	end

endmodule : ibfsm_slot_map

/* ibfsm_deframer.sv */
// Extracting end: recovers bearer, access signalling and fast signalling bits.
`timescale 1ns/1ps
`include "ibfsm_cfg.svh"

module ibfsm_deframer
	import ibfsm_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	input  wire logic [2:0]  acc_count_in,
	input  wire logic        four_wire_in,
	input  wire logic        fs_enable_in,
	ibfsm_link_if.rx         link,
	output ibfsm_bdata_t     b_data_out,
	output ibfsm_ddata_t     d_data_out,
	output logic             sb_valid_out,
	output logic             fs_bit_out,
	output logic             fs_valid_out
);

	logic [2:0]   cnt_q;
	logic         four_q;
	logic         fs_on_q;
	logic [6:0]   pos_q;
	logic [1:0]   seen_q;
	ibfsm_bdata_t b_acc_q;
	ibfsm_bdata_t b_hold_q;
	ibfsm_ddata_t d_acc_q;
	ibfsm_bdata_t b_out_q;
	ibfsm_ddata_t d_out_q;
	logic         sb_valid_q;
	logic         fs_bit_q;
	logic         fs_valid_q;

	logic         take;
	logic         frame;
	logic [2:0]   cnt_e;
	logic         four_e;
	logic         fs_on_e;
	logic [6:0]   pos;
	ibfsm_kind_e  kind0;
	ibfsm_kind_e  kind1;
	logic [2:0]   acc0;
	logic [2:0]   acc1;
	logic [3:0]   idx0;
	logic [3:0]   idx1;

	assign take = link.bit_valid;
	assign frame = take && link.fr_start;
	assign cnt_e = frame ? ibfsm_clamp_count(acc_count_in) : cnt_q; // [RULE3] [RULE20]
	assign four_e = frame ? four_wire_in : four_q; // [RULE20]
	assign fs_on_e = frame ? ibfsm_fs_active(fs_enable_in, cnt_e) : fs_on_q; // [RULE18]
	assign pos = link.sb_start ? 7'h00 : pos_q;

	ibfsm_slot_map u_map0 (
		.pos_in       (pos),
		.pair_in      (1'b0),
		.cnt_in       (cnt_e),
		.four_wire_in (four_e),
		.kind_out     (kind0),
		.acc_out      (acc0),
		.idx_out      (idx0)
	);

	ibfsm_slot_map u_map1 (
		.pos_in       (pos),
		.pair_in      (1'b1),
		.cnt_in       (cnt_e),
		.four_wire_in (four_e),
		.kind_out     (kind1),
		.acc_out      (acc1),
		.idx_out      (idx1)
	);

	// Configuration follows the first bit of each frame.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cnt_q <= `IBFSM_MIN_ACC;
			four_q <= 1'b0;
			fs_on_q <= 1'b0;
		end else if (frame) begin
			cnt_q <= cnt_e; // [RULE20]
			four_q <= four_e;
			fs_on_q <= fs_on_e; // [RULE19]
		end
	end

	// Position tracking and slot capture.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			pos_q <= 7'h00;
			b_acc_q <= '0;
			d_acc_q <= '1;
		end else if (take) begin
			pos_q <= pos + 7'h01;
			if (kind0 == KIND_B) b_acc_q[acc0][4'hF - idx0] <= link.pair_bit[0];
			if (kind0 == KIND_D) d_acc_q[acc0][idx0[0]] <= link.pair_bit[0];
			if (four_e && kind1 == KIND_B) b_acc_q[acc1][4'hF - idx1] <= link.pair_bit[1]; // [RULE15]
			if (four_e && kind1 == KIND_D) d_acc_q[acc1][idx1[0]] <= link.pair_bit[1]; // [RULE15]
		end
	end

	// B bits of one sub-block are released with the D bits of the next one.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			seen_q <= 2'h0;
			b_hold_q <= '0;
			b_out_q <= '0;
			d_out_q <= '1;
			sb_valid_q <= 1'b0;
		end else begin
			sb_valid_q <= 1'b0;
			if (take && link.sb_start) begin
				b_hold_q <= b_acc_q;
				if (seen_q != 2'h2) seen_q <= seen_q + 2'h1;
				if (seen_q == 2'h2) begin
					b_out_q <= b_hold_q; // [RULE4] [RULE5]
					d_out_q <= d_acc_q; // [RULE4] [RULE5]
					sb_valid_q <= 1'b1;
				end
			end
		end
	end

	// Fast signalling bit, taken from the first bit of pair one.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			fs_bit_q <= `IBFSM_IDLE_BIT;
			fs_valid_q <= 1'b0;
		end else begin
			fs_valid_q <= take && (kind0 == KIND_FS) && fs_on_e; // [RULE2] [RULE16] [RULE17]
			if (take && kind0 == KIND_FS) fs_bit_q <= link.pair_bit[0]; // [RULE13]
		end
	end

	assign b_data_out = b_out_q;
	assign d_data_out = d_out_q;
	assign sb_valid_out = sb_valid_q;
	assign fs_bit_out = fs_bit_q;
	assign fs_valid_out = fs_valid_q;

endmodule : ibfsm_deframer

/* ibfsm_link_asserts.sv */
// Link-level assertions for the fast signalling payload mapper.
`timescale 1ns/1ps

module ibfsm_link_asserts #(
	parameter int SB_PER_FRAME = 12
) (
	input  wire logic       clock_in,
	input  wire logic       sys_rst_in,
	input  wire logic [1:0] pair_bit_in,
	input  wire logic       bit_valid_in,
	input  wire logic       sb_start_in,
	input  wire logic       fr_start_in,
	input  wire logic       four_wire_in,
	input  wire logic       fs_active_in,
	input  wire logic [2:0] acc_count_in
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	logic [7:0] bcnt_q;
	logic [7:0] exp_q;
	logic [4:0] scnt_q;
	logic       seen_q;

	// Counts the bits of the running sub-block and its expected length.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			bcnt_q <= 8'h00;
			exp_q  <= 8'h00;
		end else if (bit_valid_in) begin
			bcnt_q <= sb_start_in ? 8'h01 : bcnt_q + 8'h01;
			if (sb_start_in)
				exp_q <= 8'(9 * acc_count_in * (four_wire_in ? 1 : 2) + 1);
		end
	end

	// Counts sub-blocks within a frame.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			scnt_q <= 5'h00;
			seen_q <= 1'h0;
		end else if (bit_valid_in && sb_start_in) begin
			scnt_q <= fr_start_in ? 5'h01 : scnt_q + 5'h01;
			seen_q <= 1'h1;
		end
	end

	a_sb_with_bit: assert property (sb_start_in |-> bit_valid_in)
		else $error("sub-block start without a line bit");
	a_frame_in_sub: assert property ($rose(fr_start_in) |-> sb_start_in && bit_valid_in)
		else $error("frame start off a sub-block start");
	a_fs_pair_same: assert property (bit_valid_in && sb_start_in && four_wire_in
		|-> pair_bit_in[0] == pair_bit_in[1])
		else $error("fast bit differs between pairs");
	a_pair_two_idle: assert property (bit_valid_in && !four_wire_in |-> pair_bit_in[1])
		else $error("pair two not idle in two-wire");
	a_fs_off_one: assert property (bit_valid_in && sb_start_in && !fs_active_in
		|-> pair_bit_in[0])
		else $error("first slot not idle with fast channel off");
	a_fs_forced: assert property (acc_count_in > 3'h4 |-> fs_active_in)
		else $error("fast channel off above four accesses");
	a_count_range: assert property (acc_count_in >= 3'h1 && acc_count_in <= 3'h6)
		else $error("access count out of range");
	a_sub_length: assert property (bit_valid_in && sb_start_in && seen_q
		|-> bcnt_q == exp_q)
		else $error("sub-block length wrong");
	a_frame_length: assert property (bit_valid_in && fr_start_in && seen_q
		|-> scnt_q == SB_PER_FRAME)
		else $error("frame length wrong");
endmodule : ibfsm_link_asserts

/* tb_isdn_bra_fast_signalling_mapper.sv */
// Loopback bench joining a framer and a deframer over one link.
`timescale 1ns/1ps

module tb_isdn_bra_fast_signalling_mapper
	import ibfsm_pkg::*;
;
	localparam int SBF = 2;
	logic         clock_in, sys_rst_in, four_wire, fs_en, tick, fs_in;
	logic         take, fs_act, sb_val, fs_out, fs_val, fexp;
	logic [2:0]   acc, acc_out;
	logic [7:0]   seq, c1, c2, s, ls;
	ibfsm_bdata_t b_in, b_out;
	ibfsm_ddata_t d_in, d_out;
	int           n_errors, cmp_count, ke, p0, wsb, pos, nsv;

	ibfsm_link_if link ();

	ibfsm_framer #(.SB_PER_FRAME(SBF)) ibfsm_framer_i (.clock_in(clock_in),
		.sys_rst_in(sys_rst_in), .acc_count_in(acc), .four_wire_in(four_wire),
		.fs_enable_in(fs_en), .tick_in(tick), .b_data_in(b_in), .d_data_in(d_in),
		.fs_bit_in(fs_in), .sb_take_out(take), .fs_active_out(fs_act),
		.acc_count_out(acc_out), .link(link));
	ibfsm_deframer ibfsm_deframer_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.acc_count_in(acc), .four_wire_in(four_wire), .fs_enable_in(fs_en),
		.link(link), .b_data_out(b_out), .d_data_out(d_out), .sb_valid_out(sb_val),
		.fs_bit_out(fs_out), .fs_valid_out(fs_val));
	ibfsm_link_asserts #(.SB_PER_FRAME(SBF)) ibfsm_link_asserts_i (.clock_in(clock_in),
		.sys_rst_in(sys_rst_in), .pair_bit_in(link.pair_bit),
		.bit_valid_in(link.bit_valid), .sb_start_in(link.sb_start),
		.fr_start_in(link.fr_start), .four_wire_in(four_wire),
		.fs_active_in(fs_act), .acc_count_in(acc_out));

	function automatic logic [15:0] mk_b(input logic [7:0] v, input logic [2:0] a);
		return {v, 1'h0, a, v[3:0]};
	endfunction : mk_b

	function automatic logic [1:0] mk_d(input logic [7:0] v, input logic [2:0] a);
		return v[1:0] ^ a[1:0];
	endfunction : mk_d

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic summarize;
		$display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize

	// Resets both ends with one configuration and streams until the deframer has recovered five sub-blocks.
	task automatic run(input int k, input logic w);
		int n;
		@(negedge clock_in);
		sys_rst_in = 1'h1;
		acc = 3'(k);
		four_wire = w;
		fs_en = w ^ acc[0];
		ke = (k == 0) ? 1 : (k == 7) ? 6 : k;
		p0 = w ? 1 + ke : 2 * ke + 1;
		repeat (2) @(negedge clock_in);
		sys_rst_in = 1'h0;
		n = 0;
		while (nsv < 5 && n < 4000) begin
			@(negedge clock_in);
			n++;
		end
		if (n >= 4000) begin
			n_errors++;
			summarize();
		end
		chk(acc_out, 16'(ke));
		chk(fs_act, fs_en || ke > 4);
		$display("test count=%0d four_wire=%0d done", k, w);
	endtask : run

	initial begin
		clock_in = 1'h0;
		forever #5 clock_in = ~clock_in;
	end

	// Presents the data of the next sub-block after each take pulse.
	always @(negedge clock_in) begin
		tick = four_wire | ~tick;
		if (sys_rst_in) seq = 8'h00;
		else if (take) seq++;
		for (int a = 0; a < 6; a++) begin
			b_in[a] = mk_b(seq, 3'(a));
			d_in[a] = mk_d(seq, 3'(a));
		end
		fs_in = seq[0];
	end

	// Watches the line bits and the recovered channels.
	always @(negedge clock_in) begin
		if (sys_rst_in) begin
			wsb = -1;
			nsv = 0;
			fexp = 1'h0;
		end else begin
			if (link.bit_valid) begin
				if (link.sb_start) begin
					if (wsb >= 0) chk({c1, c2}, mk_b(8'(wsb), 3'h0));
					wsb++;
					pos = 0;
					chk(link.pair_bit[0], fs_act ? wsb[0] : 1'h1);
				end
				if (pos >= p0 && pos < p0 + 8) begin
					c1 = {c1[6:0], link.pair_bit[0]};
					if (four_wire) c2 = {c2[6:0], link.pair_bit[1]};
				end
				if (!four_wire && pos >= p0 + 8 && pos < p0 + 16) c2 = {c2[6:0], link.pair_bit[0]};
				pos++;
			end
			if (sb_val) begin
				s = b_out[0][15:8];
				if (nsv > 0) chk(s, ls + 8'h01);
				for (int a = 0; a < ke; a++) begin
					chk(b_out[a], mk_b(s, 3'(a)));
					chk(d_out[a], mk_d(s, 3'(a)));
				end
				ls = s;
				nsv++;
			end
			if (fs_val) begin
				chk(fs_out, fexp);
				fexp = ~fexp;
			end
		end
	end

	initial begin
		n_errors = 0;
		cmp_count = 0;
		sys_rst_in = 1'h1;
		acc = 3'h1;
		four_wire = 1'h0;
		fs_en = 1'h1;
		tick = 1'h1;
		ke = 1;
		p0 = 3;
		repeat (16) @(negedge clock_in);
		for (int k = 0; k < 8; k++) begin
			run(k, 1'h0);
			run(k, 1'h1);
		end
		summarize();
	end
endmodule : tb_isdn_bra_fast_signalling_mapper
